// ### design/rcdt_pkg.sv
package rcdt_pkg;
    localparam logic [3:0] ADDR_CONFIG    = 4'h1;
    localparam logic [3:0] ADDR_CONTROL   = 4'h2;
    localparam logic [3:0] ADDR_OFF_HI    = 4'h4;
    localparam logic [3:0] ADDR_OFF_LO    = 4'h5;
    localparam logic [3:0] ADDR_WAKE      = 4'h6;
    localparam logic [3:0] ADDR_SETTLE_HI = 4'h7;
    localparam logic [3:0] ADDR_SETTLE_LO = 4'h8;
    localparam logic [3:0] ADDR_STATUS    = 4'h9;

    localparam int CTL_FSK_CAL   = 0;
    localparam int CTL_POLL_CAL  = 1;
    localparam int CTL_ASK_TRACK = 2;
    localparam int CFG_DRX_SEL   = 0;
    localparam int CFG_PS_LO     = 1;
    localparam int CFG_PS_HI     = 2;
    localparam int ST_FSK_DONE   = 0;
    localparam int ST_POLL_DONE  = 1;
    localparam int ST_XTAL_OK    = 5;
    localparam int ST_LNA_GAIN   = 6;
    localparam int ST_PLL_LOCK   = 7;

    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] CONFIG_RESET  = 8'h00;
    localparam logic [7:0] TIMER_RESET   = 8'h00;

    localparam int CLK_PERIOD_NS  = 10;
    localparam int BASE_TICK_NS   = 120000;
    localparam int BASE_TICK_CYC  = BASE_TICK_NS / CLK_PERIOD_NS;
    localparam logic [1:0] PS_X1  = 2'b00;
    localparam logic [1:0] PS_X4  = 2'b01;
    localparam logic [1:0] PS_X16 = 2'b10;
    localparam logic [17:0] MULT_X1  = 18'h0_0001;
    localparam logic [17:0] MULT_X4  = 18'h0_0004;
    localparam logic [17:0] MULT_X16 = 18'h0_0010;
    localparam logic [17:0] MULT_X64 = 18'h0_0040;
endpackage : rcdt_pkg

// ### design/rcdt_interval.sv
// One programmable interval: count units x mult base ticks per unit
module rcdt_interval
    import rcdt_pkg::*;
(
    input  wire logic        clk_i,     // Clock
    input  wire logic        rst_i,     // Async reset
    input  wire logic        start_i,   // Start pulse
    input  wire logic        tick_i,    // Base tick pulse
    input  wire logic [15:0] count_i,   // Base-unit count
    input  wire logic [17:0] mult_i,    // Ticks per unit
    output logic             busy_o,    // Running
    output logic             done_o     // End pulse
);
    typedef struct packed {
        logic [33:0] left;
        logic        busy;
        logic        done;
    } rcdt_iv_t;
    rcdt_iv_t s_reg, s_next;

    always_comb begin
        s_next      = s_reg;
        s_next.done = 1'b0;
        if (start_i) begin
            s_next.left = 34'(count_i) * 34'(mult_i);
            s_next.busy = (count_i != 16'h0000); // Zero count never runs
        end else if (s_reg.busy && tick_i) begin
            s_next.left = s_reg.left - 34'h0_0000_0001;
            if (s_reg.left == 34'h0_0000_0001) begin
                s_next.busy = 1'b0;
                s_next.done = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign busy_o = s_reg.busy;
    assign done_o = s_reg.done;
endmodule : rcdt_interval

// ### design/rcdt_top.sv
module rcdt_top
    import rcdt_pkg::*;
(
    input  wire logic       MCLK_I,          // 100 MHz clock
    input  wire logic       RST_I,           // Async reset, high
    input  wire logic       WR_EN_I,         // Register write strobe
    input  wire logic [3:0] WR_ADDR_I,       // Write address
    input  wire logic [7:0] WR_DATA_I,       // Write data
    input  wire logic [3:0] RD_ADDR_I,       // Read address
    output logic      [7:0] RD_DATA_O,       // Read data, registered
    input  wire logic       PLL_LOCKED_I,    // PLL lock, async
    input  wire logic       LNA_GAIN_I,      // LOW_NOISE_AMPLIFIER high gain, async
    input  wire logic       XTAL_VALID_I,    // Crystal clock seen, async
    input  wire logic       POLL_CAL_OK_I,   // Polling cal finished pulse
    input  wire logic       FSK_CAL_OK_I,    // FSK cal finished pulse
    input  wire logic       DRX_RESTART_I,   // Start duty cycle sequence
    output logic            POLL_CAL_RUN_O,  // Polling cal running
    output logic            FSK_CAL_RUN_O,   // FSK cal running
    output logic            ASK_TRACK_O,     // ASK peak tracking
    output logic            DRX_SELECT_O,    // Duty-cycled mode
    output logic      [1:0] OFF_PRESCALE_O,  // Off prescale
    output logic            OFF_ACTIVE_O,    // Off interval running
    output logic            WAKE_ACTIVE_O,   // Wake interval running
    output logic            SETTLE_ACTIVE_O, // Settle interval running
    output logic            SEQ_END_O        // Settle end pulse
);
    typedef struct packed {
        logic [7:0] config_r;
        logic [7:0] control;
        logic [7:0] off_hi;
        logic [7:0] off_lo;
        logic [7:0] wake;
        logic [7:0] settle_hi;
        logic [7:0] settle_lo;
        logic       poll_done;
        logic       fsk_done;
        logic [2:0] s1;
        logic [2:0] s2;
        logic [2:0] s3;
        logic [2:0] stat;
        logic [13:0] base_cnt;
        logic       tick;
        logic [7:0] rd_data;
    } rcdt_state_t;
    rcdt_state_t s_reg, s_next;

    logic        off_busy, wake_busy, settle_busy;
    logic        off_done, wake_done, settle_done;
    logic        off_start, wake_start, settle_start;
    logic [17:0] off_mult;
    logic [7:0]  status_val;

    // Sync inputs, async of MCLK
    logic [2:0] async_in;
    assign async_in = {PLL_LOCKED_I, LNA_GAIN_I, XTAL_VALID_I};

    always_comb begin
        unique case (s_reg.config_r[CFG_PS_HI:CFG_PS_LO])
            PS_X1:   off_mult = MULT_X1;
            PS_X4:   off_mult = MULT_X4;
            PS_X16:  off_mult = MULT_X16;
            default: off_mult = MULT_X64;
        endcase
    end

    always_comb begin
        status_val               = 8'h00;
        status_val[ST_PLL_LOCK]  = s_reg.stat[2];
        status_val[ST_LNA_GAIN]  = s_reg.stat[1];
        status_val[ST_XTAL_OK]   = s_reg.stat[0];
        status_val[ST_POLL_DONE] = s_reg.poll_done;
        status_val[ST_FSK_DONE]  = s_reg.fsk_done;
    end

    assign off_start    = DRX_RESTART_I && s_reg.config_r[CFG_DRX_SEL];
    assign wake_start   = off_done;
    assign settle_start = wake_done;

    always_comb begin
        s_next    = s_reg;
        s_next.s1 = async_in;
        s_next.s2 = s_reg.s1;
        s_next.s3 = s_reg.s2;
        for (int i = 0; i < 3; i++) begin
            if (s_reg.s2[i] == s_reg.s3[i]) begin
                s_next.stat[i] = s_reg.s3[i];
            end
        end
        // Shared 120 us tick
        s_next.tick = 1'b0;
        if (s_reg.base_cnt == 14'(BASE_TICK_CYC - 1)) begin
            s_next.base_cnt = 14'h0000;
            s_next.tick     = 1'b1;
        end else begin
            s_next.base_cnt = s_reg.base_cnt + 14'h0001;
        end
        if (WR_EN_I) begin
            unique case (WR_ADDR_I)
                ADDR_CONFIG:    s_next.config_r  = WR_DATA_I;
                ADDR_CONTROL: begin
                    s_next.control = WR_DATA_I;
                    if (WR_DATA_I[CTL_POLL_CAL]) begin
                        s_next.poll_done = 1'b0;
                    end
                    if (WR_DATA_I[CTL_FSK_CAL]) begin
                        s_next.fsk_done = 1'b0;
                    end
                    // Running cal is not stopped by a write of 0
                    if (s_reg.control[CTL_POLL_CAL] && !POLL_CAL_OK_I) begin
                        s_next.control[CTL_POLL_CAL] = 1'b1;
                    end
                    if (s_reg.control[CTL_FSK_CAL] && !FSK_CAL_OK_I) begin
                        s_next.control[CTL_FSK_CAL] = 1'b1;
                    end
                end
                ADDR_OFF_HI:    s_next.off_hi    = WR_DATA_I;
                ADDR_OFF_LO:    s_next.off_lo    = WR_DATA_I;
                ADDR_WAKE:      s_next.wake      = WR_DATA_I;
                ADDR_SETTLE_HI: s_next.settle_hi = WR_DATA_I;
                ADDR_SETTLE_LO: s_next.settle_lo = WR_DATA_I;
                default: ;
            endcase
        end
        // Completion after the write, so it wins over a same-cycle write
        if (s_reg.control[CTL_POLL_CAL] && POLL_CAL_OK_I) begin
            s_next.control[CTL_POLL_CAL] = 1'b0;
            s_next.poll_done             = 1'b1;
        end
        if (s_reg.control[CTL_FSK_CAL] && FSK_CAL_OK_I) begin
            s_next.control[CTL_FSK_CAL] = 1'b0;
            s_next.fsk_done             = 1'b1;
        end
        unique case (RD_ADDR_I)
            ADDR_CONFIG:    s_next.rd_data = s_reg.config_r;
            ADDR_CONTROL:   s_next.rd_data = s_reg.control;
            ADDR_OFF_HI:    s_next.rd_data = s_reg.off_hi;
            ADDR_OFF_LO:    s_next.rd_data = s_reg.off_lo;
            ADDR_WAKE:      s_next.rd_data = s_reg.wake;
            ADDR_SETTLE_HI: s_next.rd_data = s_reg.settle_hi;
            ADDR_SETTLE_LO: s_next.rd_data = s_reg.settle_lo;
            ADDR_STATUS:    s_next.rd_data = status_val;
            default:        s_next.rd_data = 8'h00;
        endcase
    end

    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            s_reg           <= '0;
            s_reg.config_r  <= CONFIG_RESET;
            s_reg.control   <= CONTROL_RESET;
            s_reg.settle_hi <= TIMER_RESET;
            s_reg.settle_lo <= TIMER_RESET;
            s_reg.off_hi    <= TIMER_RESET;
            s_reg.off_lo    <= TIMER_RESET;
            s_reg.wake      <= TIMER_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    rcdt_interval u_off (
        .clk_i   (MCLK_I),
        .rst_i   (RST_I),
        .start_i (off_start),
        .tick_i  (s_reg.tick),
        .count_i ({s_reg.off_hi, s_reg.off_lo}),
        .mult_i  (off_mult),
        .busy_o  (off_busy),
        .done_o  (off_done)
    );

    rcdt_interval u_wake (
        .clk_i   (MCLK_I),
        .rst_i   (RST_I),
        .start_i (wake_start),
        .tick_i  (s_reg.tick),
        .count_i ({8'h00, s_reg.wake}),
        .mult_i  (MULT_X1),
        .busy_o  (wake_busy),
        .done_o  (wake_done)
    );

    rcdt_interval u_settle (
        .clk_i   (MCLK_I),
        .rst_i   (RST_I),
        .start_i (settle_start),
        .tick_i  (s_reg.tick),
        .count_i ({s_reg.settle_hi, s_reg.settle_lo}),
        .mult_i  (MULT_X1),
        .busy_o  (settle_busy),
        .done_o  (settle_done)
    );

    assign RD_DATA_O       = s_reg.rd_data;
    assign POLL_CAL_RUN_O  = s_reg.control[CTL_POLL_CAL];
    assign FSK_CAL_RUN_O   = s_reg.control[CTL_FSK_CAL];
    assign ASK_TRACK_O     = s_reg.control[CTL_ASK_TRACK];
    assign DRX_SELECT_O    = s_reg.config_r[CFG_DRX_SEL];
    assign OFF_PRESCALE_O  = s_reg.config_r[CFG_PS_HI:CFG_PS_LO];
    assign OFF_ACTIVE_O    = off_busy;
    assign WAKE_ACTIVE_O   = wake_busy;
    assign SETTLE_ACTIVE_O = settle_busy;
    assign SEQ_END_O       = settle_done;
endmodule : rcdt_top

// ### dv/rcdt_checker.sv
module rcdt_checker
    import rcdt_pkg::*;
(
    input wire logic       MCLK_I, RST_I, WR_EN_I, PLL_LOCKED_I, LNA_GAIN_I, XTAL_VALID_I,
    input wire logic       POLL_CAL_OK_I, FSK_CAL_OK_I, POLL_CAL_RUN_O, FSK_CAL_RUN_O,
    input wire logic       ASK_TRACK_O, DRX_SELECT_O, OFF_ACTIVE_O, WAKE_ACTIVE_O,
    input wire logic       SETTLE_ACTIVE_O, SEQ_END_O,
    input wire logic [3:0] WR_ADDR_I, RD_ADDR_I,
    input wire logic [7:0] WR_DATA_I, RD_DATA_O,
    input wire logic [1:0] OFF_PRESCALE_O
);
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (RST_I);
    sequence ctl_wr;
        WR_EN_I && WR_ADDR_I == ADDR_CONTROL;
    endsequence
    sequence pins_steady;
        (RD_ADDR_I == ADDR_STATUS && $stable({PLL_LOCKED_I, LNA_GAIN_I, XTAL_VALID_I}))[*5];
    endsequence
    sequence poll_finish;
        POLL_CAL_RUN_O && POLL_CAL_OK_I ##1 RD_ADDR_I == ADDR_STATUS;
    endsequence
    sequence fsk_finish;
        FSK_CAL_RUN_O && FSK_CAL_OK_I ##1 RD_ADDR_I == ADDR_STATUS;
    endsequence
    chk_ask_track: assert property (ctl_wr |=> ASK_TRACK_O == $past(WR_DATA_I[2]))
        else $error("ask track bit wrong");
    chk_poll_hold: assert property (POLL_CAL_RUN_O && !POLL_CAL_OK_I |=> POLL_CAL_RUN_O)
        else $error("poll cal dropped early");
    chk_poll_clear: assert property (POLL_CAL_RUN_O && POLL_CAL_OK_I |=> !POLL_CAL_RUN_O)
        else $error("poll cal not cleared");
    chk_poll_busy: assert property (POLL_CAL_RUN_O |=> !RD_DATA_O[1] || $past(RD_ADDR_I) != 9)
        else $error("poll done while running");
    chk_poll_done: assert property (poll_finish |=> RD_DATA_O[1])
        else $error("poll done missing");
    chk_fsk_done: assert property (fsk_finish |=> RD_DATA_O[0])
        else $error("fsk done missing");
    chk_status_pins: assert property (pins_steady |=>
        RD_DATA_O[7:5] == $past({PLL_LOCKED_I, LNA_GAIN_I, XTAL_VALID_I})) else $error("status pins");
    chk_cfg_fields: assert property (WR_EN_I && WR_ADDR_I == ADDR_CONFIG |=>
        {OFF_PRESCALE_O, DRX_SELECT_O} == $past(WR_DATA_I[2:0])) else $error("config fields");
    chk_wake_follows: assert property ($fell(OFF_ACTIVE_O) |-> ##[1:3] WAKE_ACTIVE_O)
        else $error("wake did not follow off");
    chk_settle_end: assert property ($fell(SETTLE_ACTIVE_O) |-> ##[0:2] SEQ_END_O)
        else $error("no end pulse");
endmodule : rcdt_checker

bind rcdt_top rcdt_checker rcdt_checker_inst (.*);

// ### dv/rcdt_host_model.sv
module rcdt_host_model
    import rcdt_pkg::*;
(
    input  wire logic       MCLK_I,        // Clock
    output logic            WR_EN_I,       // Write strobe
    output logic      [3:0] WR_ADDR_I,     // Write address
    output logic      [7:0] WR_DATA_I,     // Write data
    output logic            DRX_RESTART_I  // Sequence restart
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        WR_EN_I = 1'b0;
        WR_ADDR_I = 4'h0;
        WR_DATA_I = 8'h00;
        DRX_RESTART_I = 1'b0;
    end
    // Released bus shows inverted address and data values
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge MCLK_I);
        #1;
        WR_EN_I = 1'b1;
        WR_ADDR_I = a;
        WR_DATA_I = d;
        @(posedge MCLK_I);
        #1;
        WR_EN_I = 1'b0;
        WR_ADDR_I = ~a;
        WR_DATA_I = ~d;
    endtask : wr
    // A one-cycle high pulse on DRX_RESTART_I restarts the sequence
    task automatic restart();
        @(posedge MCLK_I);
        #1;
        DRX_RESTART_I = 1'b1;
        @(posedge MCLK_I);
        #1;
        DRX_RESTART_I = 1'b0;
    endtask : restart
endmodule : rcdt_host_model

// ### dv/rcdt_tb_top.sv
module rcdt_tb_top
    import rcdt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic MCLK_I, RST_I, PLL_LOCKED_I, LNA_GAIN_I, XTAL_VALID_I, POLL_CAL_OK_I, FSK_CAL_OK_I;
    logic WR_EN_I, DRX_RESTART_I, POLL_CAL_RUN_O, FSK_CAL_RUN_O, ASK_TRACK_O, DRX_SELECT_O;
    logic OFF_ACTIVE_O, WAKE_ACTIVE_O, SETTLE_ACTIVE_O, SEQ_END_O, rd_req, pend;
    logic [3:0]  WR_ADDR_I, RD_ADDR_I;
    logic [7:0]  WR_DATA_I, RD_DATA_O, st;
    logic [1:0]  OFF_PRESCALE_O;
    logic [15:0] lfsr = 16'hD5C0;
    logic [39:0] tv = 40'h00_0201_0001;
    logic [7:0]  exp_q[$];
    int          n_mismatch, total_checks, cyc, n_off, n_wake, n_set, n_end;
    wire  [7:0]  ctl_view = {2'b00, ASK_TRACK_O, POLL_CAL_RUN_O, FSK_CAL_RUN_O,
                             OFF_PRESCALE_O, DRX_SELECT_O};
    rcdt_top rcdt_top_inst (.*);
    rcdt_host_model rcdt_host_model_inst (.*);
    initial begin
        MCLK_I = 1'b0;
        forever #5 MCLK_I = ~MCLK_I;
    end
    function automatic logic [15:0] nxt(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : nxt
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp8
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge MCLK_I);
        #1;
        RD_ADDR_I = a;
        rd_req = 1'b1;
        exp_q.push_back(e);
        @(posedge MCLK_I);
        #1;
        rd_req = 1'b0;
    endtask : rd
    task automatic pulse(input logic [1:0] m);
        @(posedge MCLK_I);
        #1;
        {POLL_CAL_OK_I, FSK_CAL_OK_I} = m;
        @(posedge MCLK_I);
        #1;
        {POLL_CAL_OK_I, FSK_CAL_OK_I} = 2'b00;
    endtask : pulse
    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : report_and_stop
    // Read results land one edge after the request
    always @(posedge MCLK_I) pend <= rd_req;
    always @(negedge MCLK_I) if (pend) cmp8(RD_DATA_O, exp_q.pop_front());
    // Outputs are counted at the falling edge, where they are settled
    always @(negedge MCLK_I) begin
        cyc++;
        n_off += OFF_ACTIVE_O;
        n_wake += WAKE_ACTIVE_O;
        n_set += SETTLE_ACTIVE_O;
        n_end += SEQ_END_O;
        if (cyc == 90000) begin
            n_mismatch++;
            report_and_stop();
        end
    end
    initial begin
        {RST_I, rd_req, RD_ADDR_I} = {2'b10, 4'h0};
        {PLL_LOCKED_I, LNA_GAIN_I, XTAL_VALID_I, POLL_CAL_OK_I, FSK_CAL_OK_I} = 5'h00;
        repeat (6) @(posedge MCLK_I);
        #1;
        RST_I = 1'b0;
        for (int a = 1; a <= 10; a++) rd(a[3:0], 8'h00);
        cmp8(ctl_view, 8'h00);
        $display("reset values done");
        for (int a = 4; a <= 8; a++) begin
            lfsr = nxt(lfsr);
            rcdt_host_model_inst.wr(a[3:0], lfsr[7:0]);
            rd(a[3:0], lfsr[7:0]);
        end
        for (int p = 0; p < 8; p++) begin
            rcdt_host_model_inst.wr(ADDR_CONFIG, p[7:0]);
            cmp8(ctl_view, {5'h00, p[2:0]});
        end
        $display("register access done");
        repeat (4) begin
            lfsr = nxt(lfsr);
            {PLL_LOCKED_I, LNA_GAIN_I, XTAL_VALID_I} = lfsr[2:0];
            st = {lfsr[2:0], 5'h00};
            rcdt_host_model_inst.wr(ADDR_STATUS, 8'hFF);
            repeat (4) @(posedge MCLK_I);
            rd(ADDR_STATUS, st);
        end
        $display("status done");
        rcdt_host_model_inst.wr(ADDR_CONTROL, 8'h07);
        cmp8(ctl_view & 8'h38, 8'h38);
        rd(ADDR_STATUS, st);
        rcdt_host_model_inst.wr(ADDR_CONTROL, 8'h04);
        cmp8(ctl_view & 8'h38, 8'h38);
        pulse(2'b01);
        cmp8(ctl_view & 8'h38, 8'h30);
        rd(ADDR_STATUS, st | 8'h01);
        pulse(2'b10);
        cmp8(ctl_view & 8'h38, 8'h20);
        rd(ADDR_STATUS, st | 8'h03);
        rd(ADDR_CONTROL, 8'h04);
        $display("calibration done");
        rcdt_host_model_inst.wr(ADDR_CONFIG, 8'h01);
        for (int a = 4; a <= 8; a++) rcdt_host_model_inst.wr(a[3:0], tv[8*(8-a)+:8]);
        n_off = 0;
        n_wake = 0;
        n_set = 0;
        n_end = 0;
        rcdt_host_model_inst.restart();
        for (int i = 0; i < 50000 && SEQ_END_O !== 1'b1; i++) @(negedge MCLK_I);
        repeat (2) @(posedge MCLK_I);
        cmp8(n_end[7:0], 8'h01);
        cmp8({7'h00, n_off inside {[12000:24001]}}, 8'h01);
        cmp8({7'h00, n_wake inside {[1:12001]}}, 8'h01);
        cmp8({7'h00, n_set inside {[1:12001]}}, 8'h01);
        $display("duty cycle done");
        report_and_stop();
    end
endmodule : rcdt_tb_top
